// [hw/adc_seq_ctrl.sv]
// Sequencing and register control for a 10-bit SAR converter.
// Assumes an APB master on pclk and an analog core that returns a code.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"

// Function
// [RQ1] Ref select: 01 supply, 10 amplifier, 00/11 external pin.
// [RQ2] Source 00, channel 0-3 connects analog pin 0-3.
// [RQ3] Source 00, channel 4-7 connects nothing; input floats.
// [RQ4] Channel 4-7, sources 01/10/11 pick amp, battery/4, supply/4.
// [RQ5] Software sets a non-existent channel before internal sources.
// [RQ6] Analog pin mode disables other functions and the pull-up.
// [RQ7] Analog pin mode overrides the port direction.
// [RQ8] Sampling phase lasts four converter clocks.
// [RQ9] Ten converting clocks follow; fourteen in total.
// [RQ10] Start bit low-high-low begins a conversion.
// [RQ11] Busy high during conversion, low when result valid.
// [RQ12] Software enables both interrupt enables for interrupts.
// [RQ13] Software sets divider before enabling and starting.
// [RQ14] Power bit low turns converter circuitry off.
// [RQ15] Format bit arranges result across high and low.
// [RQ16] Result ten bits wide; full scale 3FF.
// [RQ17] One step is reference divided by 1024.
// [RQ18] Conversion runs on its own without stalling the core.
// [RQ19] Busy set at start; completion sets flag and interrupt.
// [RQ20] Converter clock is system clock over two to the code.
// [RQ21] Software waits settling time after power on.
// [RQ22] Start during conversion aborts and restarts; busy stays.
// [RQ23] Format 0: left aligned 8+2; format 1: right aligned.
module adc_seq_ctrl
  import adc_seq_pkg::*;
#(
  parameter int RES_W = 10,
  parameter int NPINS = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [RES_W-1:0] core_code,
  input wire logic [NPINS-1:0] port_dir_out,
  input wire logic [NPINS-1:0] port_pull_req,
  output adc_seq_pkg::analog_ctl_t analog_ctl,
  output adc_seq_pkg::pin_ctl_t pin_ctl,
  output logic conv_irq
);
  import adc_seq_pkg::*;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  logic [7:0] ctrl0_reg;
  logic [7:0] ctrl1_reg;
  logic [NPINS-1:0] pinfn_reg;
  logic start_prev_reg;
  logic busy_reg;
  logic irq_flag_reg;
  logic gie_reg;
  logic cie_reg;
  logic [RES_W-1:0] result_reg;
  conv_state_t state_reg;
  logic [3:0] clk_cnt_reg;
  logic tick;
  logic start_pulse;
  logic done;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic [7:0] res_high;
  logic [7:0] res_low;

  logic [2:0] ext_channel_select;
  logic [1:0] input_source_select;
  logic [1:0] ref_source_select;
  logic [2:0] conv_clock_divider;
  logic converter_power_on;
  logic result_format_select;

  assign ext_channel_select = ctrl0_reg[`C0_CHAN_LSB +: 3];
  assign result_format_select = ctrl0_reg[`C0_FMT_BIT];
  assign converter_power_on = ctrl0_reg[`C0_PWR_BIT];
  assign conv_clock_divider = ctrl1_reg[`C1_DIV_LSB +: 3];
  assign ref_source_select = ctrl1_reg[`C1_REF_LSB +: 2];
  assign input_source_select = ctrl1_reg[`C1_SRC_LSB +: 2];

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // Zero wait states: every access completes in its access phase.
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign addr_ok = (paddr == `OFS_CTRL0) || (paddr == `OFS_CTRL1) ||
                   (paddr == `OFS_RES_HIGH) || (paddr == `OFS_RES_LOW) ||
                   (paddr == `OFS_PINFN) || (paddr == `OFS_STATUS);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        `OFS_CTRL0: prdata <= {24'h00_0000, ctrl0_reg[7],
                               busy_reg, ctrl0_reg[5:0]};
        `OFS_CTRL1: prdata <= {24'h00_0000, ctrl1_reg};
        `OFS_RES_HIGH: prdata <= {24'h00_0000, res_high};
        `OFS_RES_LOW: prdata <= {24'h00_0000, res_low};
        `OFS_PINFN: prdata <= {28'h000_0000, pinfn_reg};
        `OFS_STATUS: prdata <= {29'h0000_0000, cie_reg, gie_reg,
                                irq_flag_reg};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Writes land on the access edge; ready is high then by construction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl0_reg <= `CTRL0_RST;
      ctrl1_reg <= `CTRL1_RST;
      pinfn_reg <= '0;
      gie_reg <= 1'b0;
      cie_reg <= 1'b0;
    end else if (wr_en && pready) begin
      case (paddr)
        `OFS_CTRL0: ctrl0_reg <= pwdata[7:0];
        `OFS_CTRL1: ctrl1_reg <= pwdata[7:0];
        `OFS_PINFN: pinfn_reg <= pwdata[NPINS-1:0];
        `OFS_STATUS: begin
          gie_reg <= pwdata[`ST_GIE_BIT];
          cie_reg <= pwdata[`ST_CIE_BIT];
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Start detection
  // --------------------------------------------------------------------
  // [RQ10] falling start edge after high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_reg <= 1'b0;
    end else begin
      start_prev_reg <= ctrl0_reg[`C0_START_BIT];
    end
  end
  assign start_pulse = start_prev_reg && !ctrl0_reg[`C0_START_BIT] &&
                       converter_power_on;

  // [RQ20] converter clock tick
  conv_clock_div #(
    .DIV_W(3)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .div_code(conv_clock_divider),
    .restart(start_pulse),
    .tick(tick)
  );

  // --------------------------------------------------------------------
  // Conversion sequencer
  // --------------------------------------------------------------------
  // [RQ18] runs beside the bus, never stalls it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      clk_cnt_reg <= 4'h0;
    end else if (!converter_power_on) begin
      state_reg <= ST_IDLE;
      clk_cnt_reg <= 4'h0;
    end else if (start_pulse) begin
      // [RQ22] restart aborts current conversion
      state_reg <= ST_SAMPLE;
      clk_cnt_reg <= 4'h0;
    end else if (tick) begin
      case (state_reg)
        ST_SAMPLE: begin
          clk_cnt_reg <= clk_cnt_reg + 4'h1;
          // [RQ8] four sampling clocks
          if (clk_cnt_reg == `SAMPLE_CLKS - 4'h1) begin
            state_reg <= ST_CONVERT;
          end
        end
        ST_CONVERT: begin
          clk_cnt_reg <= clk_cnt_reg + 4'h1;
          // [RQ9] fourteen clocks in total
          if (clk_cnt_reg == `TOTAL_CLKS - 4'h1) begin
            state_reg <= ST_IDLE;
            clk_cnt_reg <= 4'h0;
          end
        end
        ST_IDLE: ;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  assign done = tick && !start_pulse && converter_power_on &&
                state_reg == ST_CONVERT &&
                clk_cnt_reg == `TOTAL_CLKS - 4'h1;

  // [RQ11] busy flag
  // [RQ19] busy set at start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_reg <= 1'b0;
    end else if (start_pulse) begin
      busy_reg <= 1'b1;
    end else if (done || !converter_power_on) begin
      busy_reg <= 1'b0;
    end
  end

  // [RQ16] ten-bit result captured at end
  // [RQ17] step scaling lives in the analog core
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_reg <= '0;
    end else if (done) begin
      result_reg <= core_code;
    end
  end

  // [RQ19] completion flag; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_reg <= 1'b0;
    end else if (done) begin
      irq_flag_reg <= 1'b1;
    end else if (wr_en && pready && paddr == `OFS_STATUS &&
                 pwdata[`ST_FLAG_BIT]) begin
      irq_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_irq <= 1'b0;
    end else begin
      conv_irq <= irq_flag_reg && gie_reg && cie_reg;
    end
  end

  // [RQ15] format select
  // [RQ23] left or right alignment
  always_comb begin
    if (result_format_select) begin
      res_high = {6'h00, result_reg[9:8]};
      res_low = result_reg[7:0];
    end else begin
      res_high = result_reg[9:2];
      res_low = {result_reg[1:0], 6'h00};
    end
  end

  // --------------------------------------------------------------------
  // Analog and pin switch control
  // --------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {analog_ctl.prox_amp, analog_ctl.batt_div4, analog_ctl.supply_div4,
       analog_ctl.ref_supply, analog_ctl.ref_amp, analog_ctl.ref_pin,
       analog_ctl.powered, analog_ctl.sampling} <= 8'h00;
    end else begin
      // [RQ14] power off opens every switch
      analog_ctl.powered <= converter_power_on;
      analog_ctl.sampling <= converter_power_on && state_reg == ST_SAMPLE;
      // [RQ1] reference routing
      analog_ctl.ref_supply <= converter_power_on &&
                               ref_source_select == REF_SUPPLY;
      analog_ctl.ref_amp <= converter_power_on &&
                            ref_source_select == REF_AMP;
      analog_ctl.ref_pin <= converter_power_on &&
                            (ref_source_select == REF_PIN ||
                             ref_source_select == REF_PIN_ALT);
      // [RQ4] internal sources only with channel 4-7
      analog_ctl.prox_amp <= converter_power_on &&
                             ext_channel_select[2] &&
                             input_source_select == 2'b01;
      analog_ctl.batt_div4 <= converter_power_on &&
                              ext_channel_select[2] &&
                              input_source_select == 2'b10;
      analog_ctl.supply_div4 <= converter_power_on &&
                                ext_channel_select[2] &&
                                input_source_select == 2'b11;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          analog_ctl.pin_connect[gi] <= 1'b0;
          pin_ctl.analog_mode[gi] <= 1'b0;
          pin_ctl.pull_enable[gi] <= 1'b0;
          pin_ctl.out_enable[gi] <= 1'b0;
        end else begin
          // [RQ2] pin per channel code
          // [RQ3] codes 4-7 leave input floating
          analog_ctl.pin_connect[gi] <= converter_power_on &&
            input_source_select == 2'b00 &&
            ext_channel_select == 3'(gi);
          pin_ctl.analog_mode[gi] <= pinfn_reg[gi];
          // [RQ6] analog mode drops pull-up
          pin_ctl.pull_enable[gi] <= port_pull_req[gi] && !pinfn_reg[gi];
          // [RQ7] analog mode overrides direction
          pin_ctl.out_enable[gi] <= port_dir_out[gi] && !pinfn_reg[gi];
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  busy_on_start_a: // [RQ19]
    assert property (@(posedge pclk) disable iff (!presetn)
      start_pulse |=> busy_reg)
    else $error("busy not set after start");

  sample_len_a: // [RQ8]
    assert property (@(posedge pclk) disable iff (!presetn)
      (tick && state_reg == ST_SAMPLE && clk_cnt_reg == 4'h3 &&
       !start_pulse && converter_power_on) |=> state_reg == ST_CONVERT)
    else $error("sampling did not end after four clocks");

  done_clears_busy_a: // [RQ11]
    assert property (@(posedge pclk) disable iff (!presetn)
      done |=> !busy_reg && irq_flag_reg)
    else $error("completion did not clear busy and set flag");

  restart_busy_a: // [RQ22]
    assert property (@(posedge pclk) disable iff (!presetn)
      (busy_reg && start_pulse) |=> busy_reg && state_reg == ST_SAMPLE)
    else $error("restart lost busy");

  power_off_a: // [RQ14]
    assert property (@(posedge pclk) disable iff (!presetn)
      !converter_power_on |=> analog_ctl.pin_connect == '0 &&
        !analog_ctl.ref_pin && !analog_ctl.prox_amp)
    else $error("switch closed with power off");

  float_chan_a: // [RQ3]
    assert property (@(posedge pclk) disable iff (!presetn)
      ext_channel_select[2] |=> analog_ctl.pin_connect == '0)
    else $error("pin connected for channel 4-7");

  pull_off_a: // [RQ6]
    assert property (@(posedge pclk) disable iff (!presetn)
      pinfn_reg[0] |=> !pin_ctl.pull_enable[0] && !pin_ctl.out_enable[0])
    else $error("analog pin kept digital function");

  ref_supply_a: // [RQ1]
    assert property (@(posedge pclk) disable iff (!presetn)
      (converter_power_on && ref_source_select == 2'b01) |=>
        analog_ctl.ref_supply && !analog_ctl.ref_pin)
    else $error("reference routing wrong");

  format_a: // [RQ23]
    assert property (@(posedge pclk) disable iff (!presetn)
      !result_format_select |-> res_low[5:0] == 6'h00 &&
        res_high == result_reg[9:2])
    else $error("left alignment wrong");

endmodule // adc_seq_ctrl

`default_nettype wire

// [hw/adc_seq_cfg.svh]
// Offsets, field positions, reset values and timing counts for the
// converter sequencing block. Assumes a 32-bit APB register bus.
`ifndef ADC_SEQ_CFG_SVH
`define ADC_SEQ_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define OFS_CTRL0 12'h000
`define OFS_CTRL1 12'h004
`define OFS_RES_HIGH 12'h008
`define OFS_RES_LOW 12'h00C
`define OFS_PINFN 12'h010
`define OFS_STATUS 12'h014

// ----------------------------------------------------------------------
// Control register 0 fields
// ----------------------------------------------------------------------
`define C0_CHAN_LSB 0
`define C0_FMT_BIT 4
`define C0_PWR_BIT 5
`define C0_BUSY_BIT 6
`define C0_START_BIT 7

// ----------------------------------------------------------------------
// Control register 1 fields
// ----------------------------------------------------------------------
`define C1_DIV_LSB 0
`define C1_REF_LSB 3
`define C1_SRC_LSB 6

// ----------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------
`define ST_FLAG_BIT 0
`define ST_GIE_BIT 1
`define ST_CIE_BIT 2

// ----------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------
`define CTRL0_RST 8'h00
`define CTRL1_RST 8'h00
`define SAMPLE_CLKS 4'h4
`define TOTAL_CLKS 4'hE
`define FULL_SCALE 10'h3FF

`endif

// [hw/adc_seq_pkg.sv]
// Types for the converter sequencing block.
// Assumes the constants header is included where numbers are needed.
package adc_seq_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b10
  } conv_state_t;

  typedef enum logic [1:0] {
    REF_PIN = 2'b00,
    REF_SUPPLY = 2'b01,
    REF_AMP = 2'b10,
    REF_PIN_ALT = 2'b11
  } ref_sel_t;

  // Analog switch controls towards the converter core
  typedef struct packed {
    logic [3:0] pin_connect;
    logic prox_amp;
    logic batt_div4;
    logic supply_div4;
    logic ref_supply;
    logic ref_amp;
    logic ref_pin;
    logic powered;
    logic sampling;
  } analog_ctl_t;

  // Per-pin digital controls for the shared pins
  typedef struct packed {
    logic [3:0] analog_mode;
    logic [3:0] pull_enable;
    logic [3:0] out_enable;
  } pin_ctl_t;

endpackage : adc_seq_pkg

// [hw/conv_clock_div.sv]
// Converter clock divider: emits a one-cycle tick every 2**code pclk.
// Assumes pclk is the system clock; tick replaces a divided clock.
`timescale 1ns/1ps
`default_nettype none

module conv_clock_div #(
  parameter int DIV_W = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [DIV_W-1:0] div_code,
  input wire logic restart,
  output logic tick
);

  logic [7:0] count_reg;
  logic [7:0] limit;

  assign limit = 8'((9'h001 << div_code) - 9'h001);

  // [RQ20] divide by power of two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= 8'h00;
      tick <= 1'b0;
    end else if (restart) begin
      // Preload so the first tick lands a full period after restart
      count_reg <= 8'h01;
      tick <= (limit == 8'h00);
    end else if (count_reg >= limit) begin
      count_reg <= 8'h00;
      tick <= 1'b1;
    end else begin
      count_reg <= count_reg + 8'h01;
      tick <= 1'b0;
    end
  end

endmodule // conv_clock_div

`default_nettype wire

// [tb/adc_seq_ctrl_tb.sv]
// Self-checking testbench for the converter sequencing block.
// Assumes the block answers APB with zero wait states and one clock pclk.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_cfg.svh"

module adc_seq_ctrl_tb;
  import adc_seq_pkg::*;

  // --------------------------------------------------------------------
  // Signals and instance
  // --------------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [9:0] core_code = 10'h000;
  logic [3:0] port_dir_out = 4'h0;
  logic [3:0] port_pull_req = 4'h0;
  analog_ctl_t analog_ctl;
  pin_ctl_t pin_ctl;
  logic conv_irq;
  int error_cnt = 0;
  int total_checks = 0;
  int base = 0;
  logic [31:0] rdv;
  logic er;

  localparam logic [31:0] PWR = 32'h0000_0020;
  localparam logic [31:0] STRT = 32'h0000_0080;

  always #50 pclk = ~pclk;

  adc_seq_ctrl i_adc_seq_ctrl (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_code(core_code),
    .port_dir_out(port_dir_out), .port_pull_req(port_pull_req),
    .analog_ctl(analog_ctl), .pin_ctl(pin_ctl), .conv_irq(conv_irq));

  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task check(input string what, input logic [31:0] exp,
             input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Request held until pready is seen high at a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("pready", 1, 0);
    rdv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task start_conv(input logic [31:0] c0);
    wr(`OFS_CTRL0, c0 | STRT);
    wr(`OFS_CTRL0, c0);
  endtask

  // Counts cycles to the interrupt and cycles spent sampling
  task wait_irq(output int n, output int s);
    n = 0;
    s = 0;
    while (conv_irq !== 1'b1 && n < 4000) begin
      @(posedge pclk);
      n++;
      if (analog_ctl.sampling === 1'b1) s++;
    end
  endtask

  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // --------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------
  task t_reset;
    xfer(1'b0, `OFS_CTRL0, 0);
    check("ctrl0 reset", 0, rdv);
    xfer(1'b0, `OFS_CTRL1, 0);
    check("ctrl1 reset", 0, rdv);
    xfer(1'b0, 12'h020, 0);
    check("unmapped err", 1, er);
    check("unmapped data", 0, rdv);
    $display("test reset done");
  endtask

  task t_ref;
    wr(`OFS_CTRL0, PWR);
    for (int r = 0; r < 4; r++) begin
      wr(`OFS_CTRL1, r << `C1_REF_LSB);
      repeat (3) @(posedge pclk);
      check("ref_supply", r == 1, analog_ctl.ref_supply);
      check("ref_amp", r == 2, analog_ctl.ref_amp);
      check("ref_pin", r == 0 || r == 3, analog_ctl.ref_pin);
    end
    $display("test ref done");
  endtask

  // Channel is written before the source, so no pin meets a source
  task t_src;
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 8; c++) begin
        if (s != 0 && c < 4) continue;
        wr(`OFS_CTRL0, PWR | c);
        wr(`OFS_CTRL1, s << `C1_SRC_LSB);
        repeat (3) @(posedge pclk);
        check("pin_connect", (s == 0 && c < 4) ? (1 << c) : 0,
              analog_ctl.pin_connect);
        check("prox_amp", s == 1, analog_ctl.prox_amp);
        check("batt_div4", s == 2, analog_ctl.batt_div4);
        check("supply_div4", s == 3, analog_ctl.supply_div4);
      end
    end
    wr(`OFS_CTRL1, 0);
    $display("test source done");
  endtask

  task t_pins;
    port_dir_out <= 4'hF;
    port_pull_req <= 4'hF;
    wr(`OFS_PINFN, 32'h0000_0005);
    repeat (3) @(posedge pclk);
    check("analog_mode", 4'h5, pin_ctl.analog_mode);
    check("pull_enable", 4'hA, pin_ctl.pull_enable);
    check("out_enable", 4'hA, pin_ctl.out_enable);
    wr(`OFS_PINFN, 0);
    port_dir_out <= 4'h6;
    repeat (3) @(posedge pclk);
    check("out_enable plain", 4'h6, pin_ctl.out_enable);
    $display("test pins done");
  endtask

  task t_timing;
    int n;
    int s;
    logic [9:0] cd;
    logic f;
    for (int d = 0; d < 8; d++) begin
      cd = (d == 7) ? 10'h3FF : (10'h2D7 ^ d);
      f = d[0];
      core_code <= cd;
      wr(`OFS_STATUS, 32'h0000_0007);
      wr(`OFS_CTRL1, d);
      wr(`OFS_CTRL0, PWR | (f << `C0_FMT_BIT));
      repeat (4) @(posedge pclk);
      start_conv(PWR | (f << `C0_FMT_BIT));
      wait_irq(n, s);
      if (d == 0) begin
        base = n;
        check("base in range", 1, n >= 14 && n <= 20);
      end
      check("conv length", base + 14 * ((1 << d) - 1), n);
      check("sample length", 4 << d, s);
      xfer(1'b0, `OFS_CTRL0, 0);
      check("busy after", 0, rdv[`C0_BUSY_BIT]);
      xfer(1'b0, `OFS_RES_HIGH, 0);
      check("result high", f ? {6'h00, cd[9:8]} : cd[9:2], rdv);
      xfer(1'b0, `OFS_RES_LOW, 0);
      check("result low", f ? cd[7:0] : {cd[1:0], 6'h00}, rdv);
    end
    $display("test timing done");
  endtask

  task t_abort;
    int n;
    int s;
    wr(`OFS_STATUS, 32'h0000_0007);
    wr(`OFS_CTRL1, 2);
    start_conv(PWR);
    repeat (20) @(posedge pclk);
    start_conv(PWR);
    xfer(1'b0, `OFS_CTRL0, 0);
    check("busy kept", 1, rdv[`C0_BUSY_BIT]);
    wait_irq(n, s);
    check("restart length", base + 42, n + 3);
    $display("test abort done");
  endtask

  task t_irq_power;
    int n;
    int s;
    wr(`OFS_STATUS, 32'h0000_0003);
    wr(`OFS_CTRL1, 0);
    start_conv(PWR);
    repeat (30) @(posedge pclk);
    check("irq masked", 0, conv_irq);
    xfer(1'b0, `OFS_STATUS, 0);
    check("flag set", 1, rdv[`ST_FLAG_BIT]);
    wr(`OFS_STATUS, 32'h0000_0006);
    repeat (2) @(posedge pclk);
    check("irq raised", 1, conv_irq);
    wr(`OFS_STATUS, 32'h0000_0007);
    repeat (2) @(posedge pclk);
    check("irq cleared", 0, conv_irq);
    start_conv(PWR);
    wr(`OFS_CTRL0, 0);
    repeat (2) @(posedge pclk);
    check("powered off", 0, analog_ctl.powered);
    xfer(1'b0, `OFS_CTRL0, 0);
    check("busy off", 0, rdv[`C0_BUSY_BIT]);
    start_conv(0);
    xfer(1'b0, `OFS_CTRL0, 0);
    check("start unpowered", 0, rdv[`C0_BUSY_BIT]);
    wr(`OFS_CTRL0, PWR);
    repeat (2) @(posedge pclk);
    check("powered on", 1, analog_ctl.powered);
    $display("test irq power done");
  endtask

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_ref();
    t_src();
    t_pins();
    t_timing();
    t_abort();
    t_irq_power();
    wrap_up();
  end

  // Run needs about 4300 cycles; allow a wide margin
  initial begin
    #2_000_000;
    error_cnt++;
    wrap_up();
  end

endmodule // adc_seq_ctrl_tb
`default_nettype wire
